// *** src/system_tick_timer.sv ***
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - enabled counter decrements to zero, reloads on the next counting step, then keeps decrementing
// - reload value zero stops counting at the next wrap
// - each counting step from one to zero sets the sticky wrap flag, except when a current value write lands in the same cycle
// - wrap flag at control bit 16; reading control register clears it
// - any write to current value clears count and wrap flag
// - current value clear never raises the tick request
// - debug halt holds the counter
// - control bit 2 selects clock: 0 external reference, 1 processor clock
// - control bit 1 lets reaching zero assert the tick request
// - control bit 0 enables counting
// - 24-bit reload loaded on enable and on each zero
// - events only on the step from one to zero
// - current value read returns live 24-bit count
// - calibration reads 0xC000_0000
// - counter advanced by the processor clock or by sampled reference edges, as control bit 2 selects
module system_tick_timer (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic        debug_halt_i,
    input  wire logic        ref_clk_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             tick_req_o,
    output logic             irq_o
);

    // ==========================================================
    // state
    tick_pkg::tick_state_s st_r;
    tick_pkg::tick_state_s st_nxt;
    tick_pkg::apb_req_s    req;

    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                   paddr: paddr_i, pwdata: pwdata_i};

    function automatic logic [31:0] word24(input logic [23:0] v);
        word24 = {8'h00, v};
    endfunction : word24

    // decoded register window, anything else answers with an error
    function automatic logic mapped(input logic [31:0] a);
        mapped = (a == tick_pkg::CSR_ADDR) || (a == tick_pkg::RELOAD_ADDR) ||
                 (a == tick_pkg::CURRENT_ADDR) || (a == tick_pkg::CALIB_ADDR) ||
                 (a == tick_pkg::IRQ_MASK_ADDR) || (a == tick_pkg::IRQ_STAT_ADDR);
    endfunction : mapped

    // ==========================================================
    // next state
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic step;
    logic hit_zero;
    logic ref_rise;
    logic [1:0] ev;

    always_comb begin
        st_nxt   = st_r;
        setup    = req.psel && !req.penable;
        // writes land at the access edge where ready is seen high
        acc      = req.psel && req.penable && st_r.pready;
        wr       = acc && req.pwrite;
        rd       = setup && !req.pwrite;
        hit_zero = 1'b0;
        ev       = 2'b00;
        // reference clock sampled through three stages
        st_nxt.ref_sync = {st_r.ref_sync[1:0], ref_clk_i};
        if (st_r.ref_sync[2] == st_r.ref_sync[1]) begin
            st_nxt.ref_level = st_r.ref_sync[2];
        end
        ref_rise = st_nxt.ref_level && !st_r.ref_level;
        // processor clock or reference edge
        step = st_r.clk_sel ? 1'b1 : ref_rise;
        st_nxt.tick_req = 1'b0;
        if (st_r.enable && st_r.running && step && !debug_halt_i) begin
            if (st_r.count == 24'h00_0001) begin
                st_nxt.count = 24'h00_0000;
                hit_zero     = 1'b1;
            end else if (st_r.count == 24'h00_0000) begin
                st_nxt.count = st_r.reload;
                if (st_r.reload == 24'h00_0000) begin
                    st_nxt.running = 1'b0;
                end
            end else begin
                st_nxt.count = st_r.count - 24'h00_0001;
            end
        end
        if (hit_zero) begin
            st_nxt.tick_req = st_r.irq_en;
            ev[0]           = 1'b1;
            ev[1]           = st_r.irq_en;
        end
        // ======================================================
        // apb slave, answers in the setup cycle's next edge
        st_nxt.pready  = setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = tick_pkg::APB_ERR_DATA;
        if (setup && !mapped(req.paddr)) begin
            st_nxt.pslverr = 1'b1;
        end
        if (rd) begin
            unique case (req.paddr)
                tick_pkg::CSR_ADDR: begin
                    st_nxt.prdata = 32'h0000_0000;
                    st_nxt.prdata[tick_pkg::WRAP_BIT]    = st_r.wrap;
                    st_nxt.prdata[tick_pkg::CLK_SEL_BIT] = st_r.clk_sel;
                    st_nxt.prdata[tick_pkg::IRQ_EN_BIT]  = st_r.irq_en;
                    st_nxt.prdata[tick_pkg::ENABLE_BIT]  = st_r.enable;
                    st_nxt.wrap = 1'b0;
                end
                tick_pkg::RELOAD_ADDR:   st_nxt.prdata = word24(st_r.reload);
                tick_pkg::CURRENT_ADDR:  st_nxt.prdata = word24(st_r.count);
                tick_pkg::CALIB_ADDR:    st_nxt.prdata = tick_pkg::CALIB_VALUE;
                tick_pkg::IRQ_MASK_ADDR: st_nxt.prdata = {30'h0000_0000, st_r.irq_mask};
                tick_pkg::IRQ_STAT_ADDR: begin
                    st_nxt.prdata   = {30'h0000_0000, st_r.irq_stat};
                    st_nxt.irq_stat = 2'b00;
                end
                default: st_nxt.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (req.paddr)
                tick_pkg::CSR_ADDR: begin
                    st_nxt.enable  = req.pwdata[tick_pkg::ENABLE_BIT];
                    st_nxt.irq_en  = req.pwdata[tick_pkg::IRQ_EN_BIT];
                    st_nxt.clk_sel = req.pwdata[tick_pkg::CLK_SEL_BIT];
                    if (req.pwdata[tick_pkg::ENABLE_BIT] && !st_r.enable) begin
                        st_nxt.count   = st_r.reload;
                        st_nxt.running = 1'b1;
                    end
                end
                tick_pkg::RELOAD_ADDR: begin
                    st_nxt.reload = req.pwdata[23:0];
                    if (req.pwdata[23:0] != 24'h00_0000) begin
                        st_nxt.running = 1'b1;
                    end
                end
                tick_pkg::CURRENT_ADDR: begin
                    st_nxt.count    = 24'h00_0000;
                    st_nxt.wrap     = 1'b0;
                    st_nxt.tick_req = 1'b0;
                    ev              = 2'b00;
                    hit_zero        = 1'b0;
                end
                tick_pkg::IRQ_MASK_ADDR: st_nxt.irq_mask = req.pwdata[1:0];
                tick_pkg::CALIB_ADDR: ;
                tick_pkg::IRQ_STAT_ADDR: ;
                default: ;
            endcase
        end
        // flags set after read clears so a new event wins; a current value write drops the event
        if (hit_zero) begin
            st_nxt.wrap = 1'b1;
        end
        st_nxt.irq_stat = st_nxt.irq_stat | ev;
        st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r          <= '0;
            st_r.count    <= tick_pkg::COUNT_RESET;
            st_r.irq_mask <= tick_pkg::IRQ_MASK_RESET;
            st_r.running  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata_o   = st_r.prdata;
    assign pready_o   = st_r.pready;
    assign pslverr_o  = st_r.pslverr;
    assign tick_req_o = st_r.tick_req;
    assign irq_o      = st_r.irq;

endmodule : system_tick_timer

// *** src/tick_pkg.sv ***
package tick_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [31:0] CSR_ADDR    = 32'he000_e010;
    localparam logic [31:0] RELOAD_ADDR = 32'he000_e014;
    localparam logic [31:0] CURRENT_ADDR = 32'he000_e018;
    localparam logic [31:0] CALIB_ADDR  = 32'he000_e01c;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'he000_e020;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'he000_e024;

    // ==========================================================
    // field positions
    localparam int ENABLE_BIT   = 0;
    localparam int IRQ_EN_BIT   = 1;
    localparam int CLK_SEL_BIT  = 2;
    localparam int WRAP_BIT     = 16;
    localparam int COUNT_W      = 24;

    // ==========================================================
    // reset and fixed values
    localparam logic [31:0] CSR_RESET    = 32'h0000_0000;
    localparam logic [31:0] CALIB_VALUE  = 32'hc000_0000;
    localparam logic [23:0] COUNT_RESET  = 24'h00_0000;
    localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
    localparam logic [31:0] APB_ERR_DATA = 32'h0000_0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        enable;
        logic        irq_en;
        logic        clk_sel;
        logic        wrap;
        logic [23:0] reload;
        logic [23:0] count;
        logic        running;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        tick_req;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  ref_sync;
        logic        ref_level;
    } tick_state_s;

endpackage : tick_pkg

// *** tb/tb_system_tick_down_counter.sv ***
`timescale 1ns/1ps
module tb_system_tick_down_counter;
    // ====
    // bench
    localparam logic [31:0] CSR = tick_pkg::CSR_ADDR;
    localparam logic [31:0] CUR = tick_pkg::CURRENT_ADDR;
    localparam logic [31:0] RLD = tick_pkg::RELOAD_ADDR;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt_cmd = 1'b0, err;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rdata, a, b;
    logic        pready, pslverr, tick_req, irq, dbg_halt, ref_clk;
    int          tick_cnt, t, n, error_cnt = 0, cmp_count = 0;
    system_tick_timer uut (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .debug_halt_i(dbg_halt), .ref_clk_i(ref_clk), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tick_req_o(tick_req), .irq_o(irq));
    tick_core_model core (.mclk_i(mclk), .halt_cmd_i(halt_cmd), .tick_req_i(tick_req), .debug_halt_o(dbg_halt),
        .ref_clk_o(ref_clk), .tick_cnt_o(tick_cnt));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task results;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task bound(input int k);
        if (k >= 3000) begin
            error_cnt++;
            results();
        end
    endtask : bound
    task apb(input logic w, input logic [31:0] ad, d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        for (n = 1; n < 3000 && pready !== 1'b1; n++) @(posedge mclk);
        bound(n);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task wait_tick;
        @(posedge mclk);
        for (n = 1; n < 3000 && tick_req !== 1'b1; n++) @(posedge mclk);
        bound(n);
    endtask : wait_tick
    task regs_chk;
        apb(1'b0, CSR, '0);
        chk("csr reset", rdata, tick_pkg::CSR_RESET);
        apb(1'b1, tick_pkg::CALIB_ADDR, '0);
        apb(1'b0, tick_pkg::CALIB_ADDR, '0);
        chk("calib", rdata, 32'hc000_0000);
        apb(1'b1, CSR, 32'hffff_fff8);
        apb(1'b0, CSR, '0);
        chk("csr reserved", rdata, '0);
        apb(1'b0, 32'he000_e030, '0);
        chk("unmapped", 32'(err), 32'h0000_0001);
    endtask : regs_chk
    task period_chk(input logic [31:0] ctl, rl, exp);
        apb(1'b1, RLD, rl);
        apb(1'b1, CUR, '0);
        apb(1'b1, CSR, ctl);
        wait_tick();
        wait_tick();
        chk("period", n, exp);
        chk("irq masked", 32'(irq), '0);
        apb(1'b1, CSR, '0);
        apb(1'b0, CSR, '0);
        chk("wrap set", rdata, 32'h0001_0000);
        apb(1'b0, CSR, '0);
        chk("wrap clear", rdata, '0);
        apb(1'b1, tick_pkg::IRQ_MASK_ADDR, 32'h0000_0003);
        chk("irq raised", 32'(irq), 32'h0000_0001);
        apb(1'b0, tick_pkg::IRQ_STAT_ADDR, '0);
        chk("status", rdata, 32'h0000_0003);
        chk("irq cleared", 32'(irq), '0);
        apb(1'b1, tick_pkg::IRQ_MASK_ADDR, '0);
    endtask : period_chk
    task zero_chk;
        apb(1'b1, CSR, 32'h0000_0007);
        apb(1'b1, RLD, '0);
        repeat (20) @(posedge mclk);
        apb(1'b0, CUR, '0);
        chk("stopped", rdata, '0);
        t = tick_cnt;
        repeat (20) @(posedge mclk);
        chk("no tick", tick_cnt, t);
    endtask : zero_chk
    task clear_chk;
        apb(1'b1, RLD, 32'h0000_0064);
        repeat (20) @(posedge mclk);
        t = tick_cnt;
        apb(1'b1, CUR, 32'hffff_ffff);
        repeat (10) @(posedge mclk);
        chk("clear quiet", tick_cnt, t);
        apb(1'b0, CSR, '0);
        chk("wrap cleared", rdata, 32'h0000_0007);
        apb(1'b1, CSR, '0);
        apb(1'b1, CUR, 32'h0000_1234);
        apb(1'b0, CUR, '0);
        chk("count cleared", rdata, '0);
    endtask : clear_chk
    task halt_chk;
        apb(1'b1, RLD, 32'h0000_03e8);
        apb(1'b1, CSR, 32'h0000_0007);
        halt_cmd <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, CUR, '0);
        a = rdata;
        repeat (10) @(posedge mclk);
        apb(1'b0, CUR, '0);
        b = rdata;
        chk("halt hold", b, a);
        halt_cmd <= 1'b0;
        repeat (3) @(posedge mclk);
        apb(1'b0, CUR, '0);
        chk("running", 32'(rdata < b), 32'h0000_0001);
    endtask : halt_chk
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        regs_chk();
        period_chk(32'h0000_0007, 32'h0000_0004, 32'h0000_0005);
        period_chk(32'h0000_0003, 32'h0000_0003, 32'h0000_0020);
        zero_chk();
        clear_chk();
        halt_chk();
        results();
    end
endmodule : tb_system_tick_down_counter

// *** tb/tick_core_model.sv ***
`timescale 1ns/1ps
module tick_core_model (
    input  wire logic mclk_i,
    input  wire logic halt_cmd_i,
    input  wire logic tick_req_i,
    output logic      debug_halt_o = 1'b0,
    output logic      ref_clk_o = 1'b0,
    output int        tick_cnt_o = 0
);
    // ====
    // core side: halt, free running reference, tick count
    logic [2:0] div_r = 3'h0;
    always @(posedge mclk_i) begin
        div_r <= div_r + 3'h1;
        ref_clk_o <= div_r[2];
        debug_halt_o <= halt_cmd_i;
        if (tick_req_i === 1'b1) begin
            tick_cnt_o <= tick_cnt_o + 1;
        end
    end
endmodule : tick_core_model

// *** tb/tick_sva.sv ***
`timescale 1ns/1ps
module tick_sva (
    input wire logic        mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, debug_halt_i, ref_clk_i,
    input wire logic [31:0] paddr_i, pwdata_i, prdata_o,
    input wire logic        pready_o, pslverr_o, tick_req_o, irq_o
);
    // ====
    // port checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire setup  = psel_i && !penable_i;
    wire rd     = pready_o && !pwrite_i;
    wire cnt_rd = rd && (paddr_i == tick_pkg::RELOAD_ADDR || paddr_i == tick_pkg::CURRENT_ADDR);
    answer_next_a: assert property (setup |=> pready_o) else $error("no answer");
    ready_once_a: assert property (pready_o |=> !pready_o) else $error("ready held");
    err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    tick_pulse_a: assert property (tick_req_o |=> !tick_req_o) else $error("tick held");
    clear_quiet_a: assert property (psel_i && penable_i && pready_o && pwrite_i && paddr_i == tick_pkg::CURRENT_ADDR |=> !tick_req_o [*2])
        else $error("tick after clear");
    calib_fixed_a: assert property (rd && paddr_i == tick_pkg::CALIB_ADDR |-> prdata_o == 32'hc000_0000)
        else $error("calibration value");
    csr_reserved_a: assert property (rd && paddr_i == tick_pkg::CSR_ADDR |-> (prdata_o & 32'hfffe_fff8) == '0)
        else $error("reserved bits set");
    value_width_a: assert property (cnt_rd |-> prdata_o[31:24] == '0) else $error("upper byte set");
    cover property (tick_req_o);
    cover property (irq_o);
    cover property (pslverr_o);
endmodule : tick_sva
bind system_tick_timer tick_sva u_sva (.*);
